/* File: rtl/ssel_params.svh */
/*
  Constants for the segment register selector: segment codes, reset
  selector values, field widths and reset values of the output stage.
  Assumes inclusion by bare name from rtl/ files only.
*/
`ifndef SSEL_PARAMS_SVH
`define SSEL_PARAMS_SVH

`define SSEL_SEG_W        2
`define SSEL_WORD_W       16
`define SSEL_DISP8_W      8
`define SSEL_SEG_EXTRA    2'h0
`define SSEL_SEG_CODE     2'h1
`define SSEL_SEG_STACK    2'h2
`define SSEL_SEG_DATA     2'h3
`define SSEL_RST_CODE_SEL 16'hf000
`define SSEL_RST_SEL      16'h0000
`define SSEL_RST_OFFSET   16'h0000
`define SSEL_SEG_COUNT    4

`endif

/* File: rtl/ssel_pkg.sv */
/*
  Types for the segment register selector.
  Assumes ssel_params.svh is compiled alongside.
*/
`default_nettype none

package ssel_pkg;

   // ----------------------------------------
   // Reference kinds from the decoder
   // ----------------------------------------
   typedef enum logic [2:0] {
      SSEL_REF_NONE,
      SSEL_REF_PREFETCH,
      SSEL_REF_STACK,
      SSEL_REF_DATA,
      SSEL_REF_STRING_DST
   } ssel_ref_t;

   typedef logic [1:0]  ssel_seg_t;
   typedef logic [15:0] ssel_word_t;

endpackage

`default_nettype wire

/* File: rtl/ssel_seg_file.sv */
/*
  Four-entry segment register file, one write port, one read port
  with registered read data and write data forwarded to the read.
  Assumes a single clock and the core reset.
*/
`include "ssel_params.svh"
`default_nettype none

module ssel_seg_file (
   input  wire logic             clk_in,
   input  wire logic             rstn_in,
   input  wire logic             ce_in,
   input  wire logic             wr_en_in,
   input  wire ssel_pkg::ssel_seg_t wr_seg_in,
   input  wire ssel_pkg::ssel_word_t wr_sel_in,
   input  wire ssel_pkg::ssel_seg_t rd_seg_in,
   output logic [15:0]           rd_sel_out
);

   ssel_pkg::ssel_word_t seg_mem [`SSEL_SEG_COUNT];

   // ----------------------------------------
   // Selector storage
   // ----------------------------------------
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         seg_mem[0] <= `SSEL_RST_SEL;
         seg_mem[1] <= `SSEL_RST_CODE_SEL;
         seg_mem[2] <= `SSEL_RST_SEL;
         seg_mem[3] <= `SSEL_RST_SEL;
      end else if (ce_in && wr_en_in) begin
         seg_mem[wr_seg_in] <= wr_sel_in; // [R11]
      end
   end

   // ----------------------------------------
   // Registered read, write data forwarded
   // ----------------------------------------
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rd_sel_out <= `SSEL_RST_SEL;
      end else if (ce_in) begin
         if (wr_en_in && wr_seg_in == rd_seg_in) begin
            rd_sel_out <= wr_sel_in;
         end else begin
            rd_sel_out <= seg_mem[rd_seg_in]; // [R3]
         end
      end
   end

endmodule

`default_nettype wire

/* File: rtl/ssel_offset_add.sv */
/*
  Sixteen-bit offset adder: displacement, base and index.
  Assumes operands are valid in the cycle they are presented.
*/
`include "ssel_params.svh"
`default_nettype none

module ssel_offset_add (
   input  wire logic             clk_in,
   input  wire logic             rstn_in,
   input  wire logic             ce_in,
   input  wire logic [15:0]      disp_in,
   input  wire logic             disp_short_in,
   input  wire logic [15:0]      base_in,
   input  wire logic             use_base_in,
   input  wire logic [15:0]      index_in,
   input  wire logic             use_index_in,
   output logic [15:0]           offset_out
);

   // ----------------------------------------
   // Sign extension of a short displacement
   // ----------------------------------------
   function automatic logic [15:0] sext8(input logic [7:0] v);
      sext8 = {{8{v[7]}}, v};
   endfunction

   logic [15:0] disp_ext;
   logic [15:0] next_offset;

   always_comb begin
      disp_ext    = disp_short_in ? sext8(disp_in[7:0]) : disp_in; // [R13]
      next_offset = disp_ext
                  + (use_base_in  ? base_in  : 16'h0000)
                  + (use_index_in ? index_in : 16'h0000); // [R12]
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         offset_out <= `SSEL_RST_OFFSET;
      end else if (ce_in) begin
         offset_out <= next_offset; // [R1]
      end
   end

endmodule

`default_nettype wire

/* File: rtl/ssel_selector.sv */
/*
  Segment register selector: picks the segment register for each
  memory reference and presents selector, offset and segment code.
  Assumes the decoder presents one reference per enabled cycle.
*/
`include "ssel_params.svh"
`default_nettype none

// Behaviour
// [R1] Offset sixteen bits, segment up to 64K
// [R2] Address is selector plus offset pair
// [R3] Selector comes from a segment register
// [R4] Prefetch always uses code segment
// [R5] Stack pushes and pops use stack segment; the code lets override_in replace it
// [R6] Base pointer base defaults to stack
// [R7] Other data references use data segment
// [R8] String destination uses extra segment; the code lets override_in replace it
// [R9] Override prefix replaces the default choice
// [R10] Equal selectors in segments work fine
// [R11] Only four segments; reload to reach others
// [R12] Offset sum sixteen bits, carry dropped
// [R13] Eight-bit displacement sign-extended first
// [R14] Two-bit segment code same cycle
module ssel_selector (
   input  wire logic              clk_in,
   input  wire logic              rstn_in,
   input  wire logic              ce_in,
   input  wire logic              ref_valid_in,
   input  wire ssel_pkg::ssel_ref_t ref_kind_in,
   input  wire logic              base_is_bp_in,
   input  wire logic              override_in,
   input  wire ssel_pkg::ssel_seg_t override_seg_in,
   input  wire logic [15:0]       disp_in,
   input  wire logic              disp_short_in,
   input  wire logic [15:0]       base_in,
   input  wire logic              use_base_in,
   input  wire logic [15:0]       index_in,
   input  wire logic              use_index_in,
   input  wire logic              load_en_in,
   input  wire ssel_pkg::ssel_seg_t load_seg_in,
   input  wire logic [15:0]       load_sel_in,
   output logic [1:0]             seg_code_out,
   output logic                   seg_code_valid_out,
   output logic [15:0]            sel_out,
   output logic [15:0]            offset_out,
   output logic                   addr_valid_out
);

   ssel_pkg::ssel_seg_t next_seg;
   ssel_pkg::ssel_seg_t code_q;
   logic                valid_q;

   // ----------------------------------------
   // Default choice by reference kind
   // ----------------------------------------
   function automatic ssel_pkg::ssel_seg_t default_seg(input ssel_pkg::ssel_ref_t k, input logic bp);
      case (k)
         ssel_pkg::SSEL_REF_PREFETCH:   default_seg = `SSEL_SEG_CODE;  // [R4]
         ssel_pkg::SSEL_REF_STACK:      default_seg = `SSEL_SEG_STACK; // [R5]
         ssel_pkg::SSEL_REF_STRING_DST: default_seg = `SSEL_SEG_EXTRA; // [R8]
         default: begin
            if (bp) begin
               default_seg = `SSEL_SEG_STACK; // [R6]
            end else begin
               default_seg = `SSEL_SEG_DATA; // [R7]
            end
         end
      endcase
   endfunction

   always_comb begin
      next_seg = default_seg(ref_kind_in, base_is_bp_in);
      if (override_in && ref_kind_in != ssel_pkg::SSEL_REF_PREFETCH) begin
         next_seg = override_seg_in; // [R9]
      end
   end

   // ----------------------------------------
   // Segment code for the address path
   // ----------------------------------------
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         code_q  <= `SSEL_SEG_CODE;
         valid_q <= 1'b0;
      end else if (ce_in) begin
         code_q  <= next_seg; // [R14]
         valid_q <= ref_valid_in && ref_kind_in != ssel_pkg::SSEL_REF_NONE;
      end
   end

   always_comb begin
      seg_code_out       = code_q;
      seg_code_valid_out = valid_q;
      addr_valid_out     = valid_q; // [R2]
   end

   // ----------------------------------------
   // Selector storage and offset
   // ----------------------------------------
   // Each register holds its own copy, so equal selectors need nothing special
   ssel_seg_file u_seg_file ( // [R10]
      .clk_in    (clk_in),
      .rstn_in   (rstn_in),
      .ce_in     (ce_in),
      .wr_en_in  (load_en_in),
      .wr_seg_in (load_seg_in),
      .wr_sel_in (load_sel_in),
      .rd_seg_in (next_seg),
      .rd_sel_out(sel_out)
   );

   ssel_offset_add u_offset (
      .clk_in       (clk_in),
      .rstn_in      (rstn_in),
      .ce_in        (ce_in),
      .disp_in      (disp_in),
      .disp_short_in(disp_short_in),
      .base_in      (base_in),
      .use_base_in  (use_base_in),
      .index_in     (index_in),
      .use_index_in (use_index_in),
      .offset_out   (offset_out)
   );

endmodule

`default_nettype wire

/* File: verif/ssel_selector_sva.sv */
/* Checker for ssel_selector: segment choice, pairing and refusal.
   Assumes the ssel_pkg package is compiled first. */
`default_nettype none
module ssel_selector_chk (
   input wire logic                 clk_in,
   input wire logic                 rstn_in,
   input wire logic                 ce_in,
   input wire logic                 ref_valid_in,
   input wire ssel_pkg::ssel_ref_t  ref_kind_in,
   input wire logic                 base_is_bp_in,
   input wire logic                 override_in,
   input wire ssel_pkg::ssel_seg_t  override_seg_in,
   input wire logic [1:0]           seg_code_out,
   input wire logic                 seg_code_valid_out,
   input wire logic                 addr_valid_out
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rstn_in);
   wire t  = ce_in & ref_valid_in;
   wire pf = t & (ref_kind_in == ssel_pkg::SSEL_REF_PREFETCH);
   wire sk = t & (ref_kind_in == ssel_pkg::SSEL_REF_STACK);
   wire dt = t & (ref_kind_in == ssel_pkg::SSEL_REF_DATA);
   wire sd = t & (ref_kind_in == ssel_pkg::SSEL_REF_STRING_DST);
   wire nv = ~override_in;
   pref_code_a: assert property (pf |=> seg_code_out == 2'h1 && seg_code_valid_out)
      else $error("prefetch seg");
   stack_code_a: assert property (sk && nv |=> seg_code_out == 2'h2) else $error("stack seg");
   bp_stack_a: assert property (dt && base_is_bp_in && nv |=> seg_code_out == 2'h2) else $error("bp seg");
   data_code_a: assert property (dt && !base_is_bp_in && nv |=> seg_code_out == 2'h3) else $error("data seg");
   dst_extra_a: assert property (sd && nv |=> seg_code_out == 2'h0) else $error("dst seg");
   ovr_seg_a: assert property ((sk || dt || sd) && override_in |=> seg_code_out == $past(override_seg_in))
      else $error("override seg");
   addr_pair_a: assert property (addr_valid_out == seg_code_valid_out) else $error("pair");
   refuse_ref_a: assert property (ce_in && !(pf || sk || dt || sd) |=> !seg_code_valid_out)
      else $error("refuse");
   cover property (pf);
   cover property (sd && override_in);
   cover property (dt && base_is_bp_in);
endmodule
bind ssel_selector ssel_selector_chk chk_i (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce_in),
   .ref_valid_in(ref_valid_in), .ref_kind_in(ref_kind_in), .base_is_bp_in(base_is_bp_in),
   .override_in(override_in), .override_seg_in(override_seg_in), .seg_code_out(seg_code_out),
   .seg_code_valid_out(seg_code_valid_out), .addr_valid_out(addr_valid_out));
`default_nettype wire

/* File: verif/ssel_addr_model.sv */
/* Address formation model: joins selector and offset into a pointer.
   Assumes the selector outputs on one clock. */
`default_nettype none
module ssel_addr_model (
   input  wire logic        clk_in,
   input  wire logic        rstn_in,
   input  wire logic        valid_in,
   input  wire logic [15:0] sel_in,
   input  wire logic [15:0] offset_in,
   output var  logic [31:0] ptr_out
);
   timeunit 1ns;
   timeprecision 1ns;
   always_ff @(posedge clk_in or negedge rstn_in)
      if (!rstn_in) ptr_out <= 32'h0;
      else if (valid_in) ptr_out <= {sel_in, offset_in};
endmodule
`default_nettype wire

/* File: verif/ssel_selector_test.sv */
/* Bench for ssel_selector with the address formation model.
   Assumes rtl package and header compiled first. */
`default_nettype none
module ssel_selector_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_in = 0, rstn_in = 0, ce_in = 1, rv = 0, bp = 0, ov = 0, ds = 0, ub = 0, ui = 0, le = 0;
   ssel_pkg::ssel_ref_t rk = ssel_pkg::SSEL_REF_NONE;
   ssel_pkg::ssel_seg_t os = 0, ls = 0;
   logic [15:0] d = 0, b = 0, x = 0, lv = 0, sel, off;
   logic [1:0] sc;
   logic scv, av;
   logic [31:0] ptr;
   int n_errors = 0, total_checks = 0;
   ssel_selector dut (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce_in), .ref_valid_in(rv), .ref_kind_in(rk),
      .base_is_bp_in(bp), .override_in(ov), .override_seg_in(os), .disp_in(d), .disp_short_in(ds),
      .base_in(b), .use_base_in(ub), .index_in(x), .use_index_in(ui), .load_en_in(le), .load_seg_in(ls),
      .load_sel_in(lv), .seg_code_out(sc), .seg_code_valid_out(scv), .sel_out(sel), .offset_out(off),
      .addr_valid_out(av));
   ssel_addr_model fm (.clk_in(clk_in), .rstn_in(rstn_in), .valid_in(av), .sel_in(sel), .offset_in(off),
      .ptr_out(ptr));
   initial forever #20 clk_in = ~clk_in;
   task chk(string s, logic [31:0] e, logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         n_errors++;
         $display("BAD %s exp %h got %h", s, e, g);
      end
   endtask
   task ld(logic [1:0] s, logic [15:0] v);
      @(posedge clk_in); le <= 1; ls <= s; lv <= v;
      @(posedge clk_in); le <= 0;
   endtask
   task go(ssel_pkg::ssel_ref_t k, logic p, logic o, logic [1:0] q, logic [1:0] e, logic [15:0] es, logic [15:0] eo);
      @(posedge clk_in); rv <= 1; rk <= k; bp <= p; ov <= o; os <= q;
      @(posedge clk_in); rv <= 0; #1;
      chk("code", e, sc);
      chk("sel", es, sel);
      chk("off", eo, off);
      chk("valid", 1, scv);
      chk("addr valid", 1, av);
      @(posedge clk_in); #1;
      chk("ptr", {es, eo}, ptr);
      chk("pulse", 0, scv);
   endtask
   task t_dflt;
      ld(0, 16'h1111); ld(2, 16'h2222); ld(3, 16'h3333);
      go(ssel_pkg::SSEL_REF_PREFETCH, 0, 0, 0, 1, 16'hf000, 0);
      go(ssel_pkg::SSEL_REF_STACK, 0, 0, 0, 2, 16'h2222, 0);
      go(ssel_pkg::SSEL_REF_DATA, 1, 0, 0, 2, 16'h2222, 0);
      go(ssel_pkg::SSEL_REF_DATA, 0, 0, 0, 3, 16'h3333, 0);
      go(ssel_pkg::SSEL_REF_STRING_DST, 0, 0, 0, 0, 16'h1111, 0);
      $display("defaults done");
   endtask
   task t_ovr;
      go(ssel_pkg::SSEL_REF_DATA, 1, 1, 2'h0, 2'h0, 16'h1111, 0);
      go(ssel_pkg::SSEL_REF_DATA, 1, 1, 2'h1, 2'h1, 16'hf000, 0);
      go(ssel_pkg::SSEL_REF_DATA, 1, 1, 2'h2, 2'h2, 16'h2222, 0);
      go(ssel_pkg::SSEL_REF_DATA, 1, 1, 2'h3, 2'h3, 16'h3333, 0);
      go(ssel_pkg::SSEL_REF_STRING_DST, 0, 1, 2'h3, 2'h3, 16'h3333, 0);
      go(ssel_pkg::SSEL_REF_PREFETCH, 0, 1, 0, 1, 16'hf000, 0);
      $display("override done");
   endtask
   task t_off;
      @(posedge clk_in); b <= 16'hffff; x <= 16'h0002; d <= 16'h0001; ub <= 1; ui <= 1;
      go(ssel_pkg::SSEL_REF_DATA, 0, 0, 0, 3, 16'h3333, 16'h0002);
      @(posedge clk_in); d <= 16'h00ff; ds <= 1; ui <= 0; b <= 16'h0010;
      go(ssel_pkg::SSEL_REF_DATA, 1, 0, 0, 2, 16'h2222, 16'h000f);
      @(posedge clk_in); d <= 16'h0080; ds <= 0; ub <= 0;
      go(ssel_pkg::SSEL_REF_DATA, 0, 0, 0, 3, 16'h3333, 16'h0080);
      $display("offset done");
   endtask
   task t_misc;
      @(posedge clk_in); rv <= 1; rk <= ssel_pkg::SSEL_REF_NONE; d <= 16'h0000;
      @(posedge clk_in); rv <= 0; #1;
      chk("none", 0, scv);
      ld(0, 16'h4444); ld(2, 16'h4444); ld(3, 16'h4444);
      go(ssel_pkg::SSEL_REF_STACK, 0, 0, 0, 2, 16'h4444, 16'h0000);
      go(ssel_pkg::SSEL_REF_STRING_DST, 0, 0, 0, 0, 16'h4444, 16'h0000);
      $display("misc done");
   endtask
   task t_hold;
      @(posedge clk_in); ce_in <= 0; rv <= 1; rk <= ssel_pkg::SSEL_REF_PREFETCH; le <= 1; ls <= 2'h3; lv <= 16'h5555;
      @(posedge clk_in); rv <= 0; le <= 0; #1;
      chk("hold code", 0, sc);
      chk("hold valid", 0, scv);
      chk("hold sel", 16'h4444, sel);
      @(posedge clk_in); ce_in <= 1;
      go(ssel_pkg::SSEL_REF_DATA, 0, 0, 0, 3, 16'h4444, 16'h0000);
      @(posedge clk_in); rv <= 1; rk <= ssel_pkg::SSEL_REF_DATA; le <= 1; ls <= 2'h3; lv <= 16'h6666;
      @(posedge clk_in); rv <= 0; le <= 0; #1;
      chk("fwd sel", 16'h6666, sel);
      $display("hold done");
   endtask
   task conclude;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      #50000;
      n_errors++;
      conclude;
   end
   initial begin
      repeat (3) @(posedge clk_in);
      rstn_in <= 1;
      #1;
      chk("rst code", 1, sc);
      chk("rst sel", 0, sel);
      t_dflt;
      t_ovr;
      t_off;
      t_misc;
      t_hold;
      conclude;
   end
endmodule
`default_nettype wire
